/* core/power_path_params.svh */
// Constants for the per-phase active power datapath
`ifndef POWER_PATH_PARAMS_SVH
`define POWER_PATH_PARAMS_SVH

// Register byte offsets; per-phase banks stride by one word
`define OFS_TOTAL_GAIN 8'h00
`define OFS_FUND_GAIN 8'h0C
`define OFS_TOTAL_OFFSET 8'h18
`define OFS_FUND_OFFSET 8'h24
`define OFS_VOLTAGE_LEVEL 8'h30
`define OFS_INST_POWER 8'h34
`define OFS_ACCUM_MODE 8'h40
`define OFS_CONFIG 8'h44
`define OFS_COMP_MODE 8'h48
`define OFS_TOTAL_POWER 8'h4C
`define OFS_FUND_POWER 8'h58
`define OFS_VRMS_B 8'h64
`define OFS_STATUS 8'h68
`define OFS_VGAIN_B 8'h6C
`define OFS_VRMS_OFFSET_B 8'h70
`define PHASE_STRIDE 8'h04

// Field positions and values
`define WIRING_LSB 0
`define WIRING_DELTA 2'h1
`define FILTER_STRENGTH_BIT 1
`define LINE_FREQ_BIT 14
`define STAT_TOTAL_SETTLED 0
`define STAT_FUND_SETTLED 1

// Datapath scaling
`define PWR_SHIFT 20
`define WAVE_SHIFT 4
`define GAIN_SHIFT 23
`define FLT_W 48
`define FLT_FRAC 12
`define RMS_FORM 16'h8E_2A
`define RMS_FORM_SHIFT 15

// Timing
`define CLK_HZ 10000000
`define SETTLE_STD_MS 650
`define SETTLE_STRONG_MS 1300
`define SETTLE_FUND_MS 875
`define MS_TO_CYC(ms) (64'(ms) * 64'(`CLK_HZ) / 64'd1000)

`endif

/* core/power_path_pkg.sv */
// Types for the per-phase active power datapath
`default_nettype none
`include "power_path_params.svh"
package power_path_pkg;
  typedef logic [2:0][23:0] phase24_t;
  typedef logic [2:0][27:0] phase28_t;
  typedef logic [2:0][`FLT_W-1:0] phase_acc_t;

  typedef struct packed {
    phase24_t tgain;
    phase24_t fgain;
    phase24_t toff;
    phase24_t foff;
    logic [23:0] nominal_voltage_level;
    logic [23:0] vgain_b;
    logic [23:0] vrms_off_b;
    logic [1:0] wiring;
    logic lpf_strong;
    logic freq60;
    phase_acc_t tacc;
    phase_acc_t facc;
    phase24_t inst;
    phase28_t tpow;
    phase28_t fpow;
    logic [`FLT_W-1:0] vacc;
    logic [27:0] vrms_b;
    logic [31:0] tcnt;
    logic [31:0] fcnt;
    logic power_valid;
    logic [31:0] rd_data;
  } state_t;
endpackage
`default_nettype wire

/* core/power_path.sv */
// Per-phase active power datapath with gain/offset correction
//
// Behaviour
// - Wiring field value 01 selects delta, with phase B as reference.
// - In delta wiring every phase B power result reads as zero.
// - In delta the A-C line voltage rms lands in phase B rms, corrected.
// - Each phase multiplies v and i, then low-pass filters the product.
// - Filter strength bit clear gives the 650 ms standard response.
// - Filter strength bit set gives the slower 1300 ms strong response.
// - Waveform registers hold instantaneous power divided by 2^4.
// - Waveform registers read back as 24-bit values in bits 23:0.
// - Compensation bit 14 picks 50 Hz (0) or 60 Hz (1) line frequency.
// - Fundamental power settles within 375 ms to 875 ms.
// - Gain scales filtered power by one plus gain over 2^23.
// - Gain 0xC00000 halves the power, 0x400000 adds half.
// - Total gains act on total power only, fund gains on fund only.
// - Separate signed offsets per phase, one LSB per multiplier LSB.
// - 24-bit signed registers read sign-extended to 28 bits in 32.
//
// Decided for this implementation: the address map and the plain strobed port.
`default_nettype none
module power_path
  import power_path_pkg::*;
#(
  parameter int unsigned SHIFT_STD = 10,
  parameter int unsigned SHIFT_STRONG = 11,
  parameter int unsigned SHIFT_FUND_50 = 12,
  parameter int unsigned SHIFT_FUND_60 = 11,
  parameter int unsigned SETTLE_STD_CYC =
    32'(`MS_TO_CYC(`SETTLE_STD_MS)),
  parameter int unsigned SETTLE_STRONG_CYC =
    32'(`MS_TO_CYC(`SETTLE_STRONG_MS)),
  parameter int unsigned SETTLE_FUND_CYC =
    32'(`MS_TO_CYC(`SETTLE_FUND_MS))
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Converter sample streams
  input wire logic sample_valid,
  input wire logic [23:0] volt_a,
  input wire logic [23:0] volt_b,
  input wire logic [23:0] volt_c,
  input wire logic [23:0] curr_a,
  input wire logic [23:0] curr_b,
  input wire logic [23:0] curr_c,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  // Filtered power results for the energy stage
  output logic power_valid,
  output logic [27:0] total_power_a,
  output logic [27:0] total_power_b,
  output logic [27:0] total_power_c,
  output logic [27:0] fund_power_a,
  output logic [27:0] fund_power_b,
  output logic [27:0] fund_power_c,
  output logic [27:0] phase_b_voltage_rms
);

  localparam int FW = `FLT_W;
  localparam int FR = `FLT_FRAC;

  state_t q;
  state_t d;

  phase24_t volt;
  phase24_t curr;
  phase_acc_t tacc_d;
  phase_acc_t facc_d;
  phase24_t inst_d;
  phase28_t tpow_d;
  phase28_t fpow_d;
  logic delta;
  logic fund_enable;
  logic [4:0] tshift;
  logic [4:0] fshift;
  logic [31:0] tsettle_cyc;

  assign volt = {volt_c, volt_b, volt_a};
  assign curr = {curr_c, curr_b, curr_a};
  assign delta = q.wiring == `WIRING_DELTA;
  // Fundamental path idles until a positive voltage level is loaded
  assign fund_enable = !q.nominal_voltage_level[23] && (q.nominal_voltage_level != 24'h00_0000);
  assign tshift = q.lpf_strong ? 5'(SHIFT_STRONG) : 5'(SHIFT_STD);
  assign fshift = q.freq60 ? 5'(SHIFT_FUND_60) : 5'(SHIFT_FUND_50);
  assign tsettle_cyc = q.lpf_strong ? 32'(SETTLE_STRONG_CYC)
                                    : 32'(SETTLE_STD_CYC);

  function automatic logic [27:0] apply_gain(input logic signed [27:0] x,
                                             input logic [23:0] g,
                                             input logic [23:0] ofs);
    logic signed [51:0] prod;
    prod = x * $signed(g);
    apply_gain = 28'(x + 28'(prod >>> `GAIN_SHIFT)
                 + $signed({{4{ofs[23]}}, ofs}));
  endfunction

  function automatic logic [31:0] sext_word(input logic [23:0] r);
    sext_word = {4'h0, {4{r[23]}}, r};
  endfunction

  function automatic logic [FW-1:0] lowpass(input logic [FW-1:0] acc,
                                            input logic [FW-1:0] x,
                                            input logic [4:0] sh);
    logic signed [FW-1:0] step;
    step = ($signed(x) - $signed(acc)) >>> sh;
    lowpass = FW'($signed(acc) + step);
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic signed [47:0] prod;
      logic signed [27:0] pw;
      logic [FW-1:0] pin;
      logic signed [27:0] tavg;
      logic signed [27:0] favg;
      logic zero_b;

      assign zero_b = (g == 1) && delta;
      assign prod = $signed(volt[g]) * $signed(curr[g]);
      assign pw = 28'(prod >>> `PWR_SHIFT);
      assign pin = {{(FW - 28 - FR){pw[27]}}, pw, {FR{1'b0}}};
      assign tacc_d[g] = lowpass(q.tacc[g], pin, tshift);
      assign facc_d[g] = fund_enable ? lowpass(q.facc[g], pin, fshift)
                                     : '0;
      assign tavg = 28'($signed(tacc_d[g]) >>> FR);
      assign favg = 28'($signed(facc_d[g]) >>> FR);
      assign inst_d[g] = zero_b ? 24'h00_0000
                                : 24'(pw >>> `WAVE_SHIFT);
      // Each phase uses only its own gain and offset pair
      assign tpow_d[g] = zero_b ? 28'h000_0000
        : apply_gain(tavg, q.tgain[g], q.toff[g]);
      assign fpow_d[g] = (zero_b || !fund_enable) ? 28'h000_0000
        : apply_gain(favg, q.fgain[g], q.foff[g]);
    end
  endgenerate

  // Line voltage A-C magnitude for the delta rms estimate
  logic signed [24:0] vdiff;
  logic [24:0] vabs;
  logic [FW-1:0] vin;
  logic [FW-1:0] vacc_d;
  logic [27:0] vmean;
  logic [43:0] vform;
  logic [27:0] vrms_d;

  assign vdiff = 25'($signed(volt_a)) - 25'($signed(volt_c));
  assign vabs = vdiff[24] ? 25'(-vdiff) : 25'(vdiff);
  assign vin = {{(FW - 25 - FR){1'b0}}, vabs, {FR{1'b0}}};
  assign vacc_d = lowpass(q.vacc, vin, 5'(SHIFT_STD));
  assign vmean = 28'(vacc_d >> FR);
  // Mean-absolute times the sine form factor stands in for a true rms
  assign vform = 44'(vmean) * 44'(`RMS_FORM);
  assign vrms_d = apply_gain(28'(vform >> `RMS_FORM_SHIFT), q.vgain_b,
                             q.vrms_off_b);

  always_comb begin
    d = q;
    d.rd_data = 32'h0000_0000;
    d.power_valid = 1'b0;

    // Settling counters restart whenever their filter setting changes
    if (q.tcnt < tsettle_cyc) begin
      d.tcnt = q.tcnt + 32'h0000_0001;
    end
    if (q.fcnt < 32'(SETTLE_FUND_CYC)) begin
      d.fcnt = q.fcnt + 32'h0000_0001;
    end

    // Samples use the registers as they stand before this edge's write
    if (sample_valid) begin
      d.tacc = tacc_d;
      d.facc = facc_d;
      d.inst = inst_d;
      d.tpow = tpow_d;
      d.fpow = fpow_d;
      d.power_valid = 1'b1;
      if (delta) begin
        d.vacc = vacc_d;
        d.vrms_b = vrms_d;
      end else begin
        d.vacc = '0;
        d.vrms_b = 28'h000_0000;
      end
    end

    if (reg_wr) begin
      for (int p = 0; p < 3; p++) begin
        if (reg_addr == `OFS_TOTAL_GAIN + 8'(p * 4)) begin
          d.tgain[p] = reg_wr_data[23:0];
        end
        if (reg_addr == `OFS_FUND_GAIN + 8'(p * 4)) begin
          d.fgain[p] = reg_wr_data[23:0];
        end
        if (reg_addr == `OFS_TOTAL_OFFSET + 8'(p * 4)) begin
          d.toff[p] = reg_wr_data[23:0];
        end
        if (reg_addr == `OFS_FUND_OFFSET + 8'(p * 4)) begin
          d.foff[p] = reg_wr_data[23:0];
        end
      end
      case (reg_addr)
        `OFS_VOLTAGE_LEVEL: begin
          d.nominal_voltage_level = reg_wr_data[23:0];
          d.fcnt = 32'h0000_0000;
        end
        `OFS_ACCUM_MODE: begin
          d.wiring = reg_wr_data[`WIRING_LSB +: 2];
        end
        `OFS_CONFIG: begin
          d.lpf_strong = reg_wr_data[`FILTER_STRENGTH_BIT];
          d.tcnt = 32'h0000_0000;
        end
        `OFS_COMP_MODE: begin
          d.freq60 = reg_wr_data[`LINE_FREQ_BIT];
          d.fcnt = 32'h0000_0000;
        end
        `OFS_VGAIN_B: begin
          d.vgain_b = reg_wr_data[23:0];
        end
        `OFS_VRMS_OFFSET_B: begin
          d.vrms_off_b = reg_wr_data[23:0];
        end
        default: begin
          d.wiring = d.wiring;
        end
      endcase
    end

    if (reg_rd) begin
      for (int p = 0; p < 3; p++) begin
        if (reg_addr == `OFS_TOTAL_GAIN + 8'(p * 4)) begin
          d.rd_data = sext_word(q.tgain[p]);
        end
        if (reg_addr == `OFS_FUND_GAIN + 8'(p * 4)) begin
          d.rd_data = sext_word(q.fgain[p]);
        end
        if (reg_addr == `OFS_TOTAL_OFFSET + 8'(p * 4)) begin
          d.rd_data = sext_word(q.toff[p]);
        end
        if (reg_addr == `OFS_FUND_OFFSET + 8'(p * 4)) begin
          d.rd_data = sext_word(q.foff[p]);
        end
        if (reg_addr == `OFS_INST_POWER + 8'(p * 4)) begin
          d.rd_data = {8'h00, q.inst[p]};
        end
        if (reg_addr == `OFS_TOTAL_POWER + 8'(p * 4)) begin
          d.rd_data = {4'h0, q.tpow[p]};
        end
        if (reg_addr == `OFS_FUND_POWER + 8'(p * 4)) begin
          d.rd_data = {4'h0, q.fpow[p]};
        end
      end
      case (reg_addr)
        `OFS_VOLTAGE_LEVEL: d.rd_data = sext_word(q.nominal_voltage_level);
        `OFS_ACCUM_MODE: d.rd_data = 32'(q.wiring) << `WIRING_LSB;
        `OFS_CONFIG: d.rd_data = 32'(q.lpf_strong) << `FILTER_STRENGTH_BIT;
        `OFS_COMP_MODE: d.rd_data = 32'(q.freq60) << `LINE_FREQ_BIT;
        `OFS_VRMS_B: d.rd_data = {4'h0, q.vrms_b};
        `OFS_VGAIN_B: d.rd_data = sext_word(q.vgain_b);
        `OFS_VRMS_OFFSET_B: d.rd_data = sext_word(q.vrms_off_b);
        `OFS_STATUS: begin
          d.rd_data[`STAT_TOTAL_SETTLED] = q.tcnt >= tsettle_cyc;
          d.rd_data[`STAT_FUND_SETTLED] =
            fund_enable && (q.fcnt >= 32'(SETTLE_FUND_CYC));
        end
        default: d.rd_data = d.rd_data;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rd_data = q.rd_data;
  assign power_valid = q.power_valid;
  assign total_power_a = q.tpow[0];
  assign total_power_b = q.tpow[1];
  assign total_power_c = q.tpow[2];
  assign fund_power_a = q.fpow[0];
  assign fund_power_b = q.fpow[1];
  assign fund_power_c = q.fpow[2];
  assign phase_b_voltage_rms = q.vrms_b;

endmodule // power_path
`default_nettype wire

/* sim/power_path_properties.sv */
// Port-level assertions for the active power datapath
`default_nettype none
module power_path_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Watched ports
  input wire logic sample_valid,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rd_data,
  input wire logic power_valid,
  input wire logic [27:0] total_power_a,
  input wire logic [27:0] total_power_b,
  input wire logic [27:0] fund_power_b,
  input wire logic [27:0] phase_b_voltage_rms
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence rd_of(logic [7:0] lo, logic [7:0] hi);
    reg_rd && reg_addr >= lo && reg_addr <= hi;
  endsequence
  AST_VALID_PULSE: assert property (sample_valid |=> power_valid)
    else $error("no result pulse after sample");
  AST_NO_SPURIOUS: assert property (!sample_valid |=> !power_valid)
    else $error("result pulse without sample");
  AST_HOLD_A: assert property (
    !sample_valid |=> $stable(total_power_a))
    else $error("total power moved between samples");
  AST_RD_IDLE: assert property (
    !reg_rd |=> reg_rd_data == 32'h0000_0000)
    else $error("read data outside read slot");
  AST_WAVE_PAD: assert property (
    rd_of(8'h34, 8'h3C) |=> reg_rd_data[31:24] == 8'h00)
    else $error("waveform read not zero padded");
  AST_SEXT: assert property (
    rd_of(8'h00, 8'h30) |=> reg_rd_data[31:28] == 4'h0
    && reg_rd_data[27:24] == {4{reg_rd_data[23]}})
    else $error("signed register read not sign extended");
  AST_RMS_PAD: assert property (
    rd_of(8'h64, 8'h64) |=> reg_rd_data[31:28] == 4'h0)
    else $error("rms read not padded");
  AST_DELTA_B_ZERO: assert property (
    power_valid && phase_b_voltage_rms != 28'h000_0000
    |-> total_power_b == 28'h000_0000 && fund_power_b == 28'h000_0000)
    else $error("phase B power nonzero in delta");
endmodule // power_path_properties
bind power_path power_path_properties chk_inst (.clock, .sys_rst,
  .sample_valid, .reg_addr, .reg_rd, .reg_rd_data, .power_valid,
  .total_power_a, .total_power_b, .fund_power_b, .phase_b_voltage_rms);
`default_nettype wire

/* sim/host.sv */
// Host register master model: one-cycle strobes, read data one cycle later
`default_nettype none
module host (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wr_data,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr_data = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Data is taken mid-cycle while it stands, clear of the edge that drops it
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rd_data;
  endtask
endmodule // host
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the per-phase active power datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid = 1'b0;
  logic [23:0] vs = 24'h00_0000, cs = 24'h00_0000, vc = 24'h00_0000;
  logic [7:0] reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data, rd;
  logic reg_wr, reg_rd, power_valid;
  logic [27:0] tpa, tpb, tpc, fpa, fpb, fpc, rms;
  int err_count = 0;
  int num_checks = 0;
  always #50 clock = ~clock;
  host host_inst (.clock(clock), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data));
  // Short settle counts so the status bits can be seen within the run
  power_path #(.SETTLE_STD_CYC(20), .SETTLE_STRONG_CYC(40),
    .SETTLE_FUND_CYC(30)) power_path_inst (.clock(clock), .sys_rst(sys_rst),
    .sample_valid(sample_valid), .volt_a(vs), .volt_b(vs), .volt_c(vc),
    .curr_a(cs), .curr_b(cs), .curr_c(cs), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .power_valid(power_valid), .total_power_a(tpa),
    .total_power_b(tpb), .total_power_c(tpc), .fund_power_a(fpa),
    .fund_power_b(fpb), .fund_power_c(fpc), .phase_b_voltage_rms(rms));
  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask
  // Samples of 2^20 give a product of 2^20 after scaling, so sums stay exact
  task automatic sample(input logic [23:0] v, c, v3);
    @(posedge clock);
    sample_valid <= 1'b1;
    vs <= v;
    cs <= c;
    vc <= v3;
    @(posedge clock);
    sample_valid <= 1'b0;
    for (int n = 0; n < 4 && power_valid !== 1'b1; n++) @(negedge clock);
    if (power_valid !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic regs_scn;
    do_reset();
    host_inst.rd(8'h18, rd);
    check("offset_rst", rd, 32'h0000_0000);
    host_inst.wr(8'h00, 32'hA0C0_0000);
    host_inst.rd(8'h00, rd);
    check("gain_neg", rd, 32'h0FC0_0000);
    host_inst.wr(8'h34, 32'h0000_1234);
    host_inst.rd(8'h34, rd);
    check("wave_ro", rd, 32'h0000_0000);
    host_inst.rd(8'hFC, rd);
    check("unmapped", rd, 32'h0000_0000);
  endtask
  task automatic gain_scn;
    logic [23:0] g [3] = '{24'h00_0000, 24'h40_0000, 24'hC0_0000};
    logic [27:0] e [3] = '{28'h000_0400, 28'h000_0600, 28'h000_0200};
    for (int k = 0; k < 3; k++) begin
      do_reset();
      host_inst.wr(8'h00, {8'h00, g[k]});
      host_inst.wr(8'h10, {8'h00, g[k]});
      sample(24'h10_0000, 24'h10_0000, 24'h10_0000);
      check("tot_a", tpa, e[k]);
      check("tot_b", tpb, 28'h000_0400);
      check("fund_a", fpa, 28'h000_0000);
      check("rms_wye", rms, 28'h000_0000);
      host_inst.rd(8'h34, rd);
      check("wave_a", rd, 32'h0001_0000);
    end
  endtask
  task automatic fund_scn;
    for (int k = 0; k < 2; k++) begin
      do_reset();
      host_inst.wr(8'h30, 32'h0007_8000);
      host_inst.wr(8'h48, k ? 32'h0000_4000 : 32'h0000_0000);
      host_inst.wr(8'h0C, 32'h0040_0000);
      sample(24'h10_0000, 24'h10_0000, 24'h10_0000);
      check("fund_a", fpa, k ? 28'h000_0300 : 28'h000_0180);
      check("fund_c", fpc, k ? 28'h000_0200 : 28'h000_0100);
      check("tot_a", tpa, 28'h000_0400);
    end
  endtask
  // Second sample uses the standard filter on the state left by the strong one
  task automatic flt_scn;
    do_reset();
    host_inst.wr(8'h44, 32'h0000_0002);
    host_inst.wr(8'h18, 32'h00FF_FFF0);
    sample(24'h10_0000, 24'h10_0000, 24'h10_0000);
    check("strong_a", tpa, 28'h000_01F0);
    check("tot_c", tpc, 28'h000_0200);
    host_inst.wr(8'h44, 32'h0000_0000);
    sample(24'h10_0000, 24'h10_0000, 24'h10_0000);
    check("std_a", tpa, 28'h000_05EF);
    check("std_c", tpc, 28'h000_05FF);
  endtask
  task automatic delta_scn;
    do_reset();
    host_inst.wr(8'h30, 32'h0007_8000);
    host_inst.wr(8'h40, 32'h0000_0001);
    host_inst.wr(8'h70, 32'h0000_0010);
    sample(24'h10_0000, 24'h10_0000, 24'h00_0000);
    check("tot_b", tpb, 28'h000_0000);
    check("fund_b", fpb, 28'h000_0000);
    check("tot_a", tpa, 28'h000_0400);
    host_inst.rd(8'h38, rd);
    check("wave_b", rd, 32'h0000_0000);
    host_inst.rd(8'h64, rd);
    check("rms_b", rd, 32'h0000_0481);
    check("rms_port", rms, 28'h000_0481);
  endtask
  task automatic stat_scn;
    do_reset();
    host_inst.rd(8'h68, rd);
    check("stat_rst", rd, 32'h0000_0000);
    host_inst.wr(8'h30, 32'h0007_8000);
    repeat (45) @(posedge clock);
    host_inst.rd(8'h68, rd);
    check("stat_std", rd, 32'h0000_0003);
    host_inst.wr(8'h44, 32'h0000_0002);
    repeat (25) @(posedge clock);
    host_inst.rd(8'h68, rd);
    check("stat_strong", rd, 32'h0000_0002);
    repeat (20) @(posedge clock);
    host_inst.rd(8'h68, rd);
    check("stat_strong_done", rd, 32'h0000_0003);
  endtask
  initial begin
    do_reset();
    regs_scn();
    gain_scn();
    fund_scn();
    flt_scn();
    delta_scn();
    stat_scn();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
